// ### rtl/frame_align_watch.sv
// Operation
// - Glide enabled: offset changes step gradually
// - Calibration bit self-clears when sequence ends
// - Holdover, zero, divider reset, ramp, release
// - Glide forced internally while calibrating; offset ramps to zero and back
// - Holdover held from hold step through ramp; dropped in release step
// - Tolerance code n means beyond n+1 UI
// - Alarm when Sync misaligned beyond tolerance
// - Monitor register at 7C, reset 0x2B
// - Start bit write launches full calibration
`timescale 1ns/1ps

module frame_align_watch
    import frame_align_watch_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // Microprocessor port
    input  wire logic             cs,
    input  wire logic             wr_en,
    input  wire logic             rd_en,
    input  wire logic [7:0]       addr,
    input  wire logic [7:0]       wdata,
    output logic      [7:0]       rdata,
    // Phase offset settings
    input  wire logic             ofs_wr,
    input  wire logic [OFS_W-1:0] ofs_value,
    output logic      [OFS_W-1:0] ofs_applied,
    // Sync monitor
    input  wire logic             sync_in,
    input  wire logic             ref_clk_in,
    input  wire logic             frame_mark,
    input  wire logic             alarm_clr,
    output logic                  sync_alarm,
    // Core control
    output logic                  holdover,
    output logic                  div_reset,
    output logic                  phase_shift_glide
);

    // ------------------------------------------------------------
    // Registers and pin synchronisers
    // ------------------------------------------------------------
    logic [7:0]       mon_r;
    logic             cal_go_r;
    logic [7:0]       rdata_r;
    logic [2:0]       sync_s_r;
    logic [2:0]       ref_s_r;
    logic [OFS_W-1:0] target_r;
    logic [OFS_W-1:0] applied_r;
    logic [GDIV_W-1:0] gdiv_r;
    logic [UI_W-1:0]  since_mark_r;
    logic [UI_W-1:0]  pend_r;
    logic             pend_on_r;
    logic             alarm_r;
    logic             hold_r;
    logic             divrst_r;
    cal_state_t       cal_r;
    cal_state_t       cal_nxt;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire             mon_wr    = cs && wr_en && (addr == MON_ADDR);
    wire             cal_wr    = cs && wr_en && (addr == CAL_ADDR);
    wire             cal_start = cal_wr && wdata[CAL_BIT];
    wire             glide_on  = mon_r[GLIDE_BIT];
    wire [UI_W-1:0]  tol_ui    = {1'b0, mon_r[TOL_HI:TOL_LO]} + UI_ONE;
    wire [7:0]       rd_mux    = (addr == MON_ADDR) ? mon_r :
                                 (addr == CAL_ADDR) ? {7'h00, cal_go_r} : READ_ZERO;
    wire             sync_edge = sync_s_r[1] && !sync_s_r[2];
    wire             ref_edge  = ref_s_r[1] && !ref_s_r[2];
    wire             step_en   = (gdiv_r == GDIV_LAST);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mon_r   <= MON_RESET;
            rdata_r <= READ_ZERO;
        end else begin
            if (mon_wr)
                mon_r <= wdata;
            if (cs && rd_en)
                rdata_r <= rd_mux;
        end
    end

    // Start bit: set by software, cleared by hardware at sequence end
    always_ff @(posedge clk_sys) begin
        if (srst)
            cal_go_r <= 1'b0;
        else if (cal_start && cal_r == CAL_IDLE)
            cal_go_r <= 1'b1;
        else if (cal_r == CAL_DONE)
            cal_go_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Calibration sequence
    // ------------------------------------------------------------
    wire at_zero   = (applied_r == OFS_ZERO);
    wire at_target = (applied_r == target_r);

    always_comb begin
        cal_nxt = cal_r;
        unique case (cal_r)
            CAL_IDLE:   if (cal_go_r) cal_nxt = CAL_HOLD;
            CAL_HOLD:   cal_nxt = CAL_ZERO;
            CAL_ZERO:   if (at_zero) cal_nxt = CAL_DIVRST;
            CAL_DIVRST: cal_nxt = CAL_RAMP;
            CAL_RAMP:   if (at_target) cal_nxt = CAL_DONE;
            CAL_DONE:   cal_nxt = CAL_IDLE;
        endcase
    end

    wire calibrating = (cal_r != CAL_IDLE);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cal_r    <= CAL_IDLE;
            hold_r   <= 1'b0;
            divrst_r <= 1'b0;
        end else begin
            cal_r    <= cal_nxt;
            hold_r   <= (cal_nxt != CAL_IDLE) && (cal_nxt != CAL_DONE);
            divrst_r <= (cal_nxt == CAL_DIVRST);
        end
    end

    // ------------------------------------------------------------
    // Phase offset glide
    // ------------------------------------------------------------
    wire [OFS_W-1:0] goal = (cal_r == CAL_ZERO) ? OFS_ZERO : target_r;
    wire             must_glide = glide_on || calibrating;
    wire [OFS_W-1:0] step_val =
        ($signed(goal) > $signed(applied_r)) ? applied_r + OFS_ONE :
        ($signed(goal) < $signed(applied_r)) ? applied_r - OFS_ONE : applied_r;

    always_ff @(posedge clk_sys) begin
        if (srst)
            gdiv_r <= GDIV_ZERO;
        else if (step_en)
            gdiv_r <= GDIV_ZERO;
        else
            gdiv_r <= gdiv_r + GDIV_ONE;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            target_r  <= OFS_ZERO;
            applied_r <= OFS_ZERO;
        end else begin
            if (ofs_wr)
                target_r <= ofs_value;
            if (!must_glide)
                applied_r <= goal;
            else if (step_en && cal_r != CAL_HOLD && cal_r != CAL_DIVRST)
                applied_r <= step_val;
        end
    end

    // ------------------------------------------------------------
    // Sync monitor
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_s_r <= 3'b000;
            ref_s_r  <= 3'b000;
        end else begin
            sync_s_r <= {sync_s_r[1:0], sync_in};
            ref_s_r  <= {ref_s_r[1:0], ref_clk_in};
        end
    end

    // UI distance from the last frame mark, saturating
    always_ff @(posedge clk_sys) begin
        if (srst)
            since_mark_r <= UI_SAT;
        else if (frame_mark)
            since_mark_r <= UI_ZERO;
        else if (ref_edge && since_mark_r != UI_SAT)
            since_mark_r <= since_mark_r + UI_ONE;
    end

    // A late Sync is checked on its edge; an early one waits for the next mark
    wire late_ok   = (since_mark_r <= tol_ui);
    wire early_bad = pend_on_r && ref_edge && !frame_mark && (pend_r >= tol_ui);
    wire early_ok  = pend_on_r && frame_mark;
    wire misalign  = early_bad;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pend_on_r <= 1'b0;
            pend_r    <= UI_ZERO;
        end else if (sync_edge) begin
            pend_on_r <= !late_ok && !frame_mark;
            pend_r    <= UI_ZERO;
        end else if (early_ok || early_bad) begin
            pend_on_r <= 1'b0;
        end else if (pend_on_r && ref_edge) begin
            pend_r    <= pend_r + UI_ONE;
        end
    end

    // Set wins over clear
    always_ff @(posedge clk_sys) begin
        if (srst)
            alarm_r <= 1'b0;
        else if (misalign)
            alarm_r <= 1'b1;
        else if (alarm_clr)
            alarm_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata             = rdata_r;
    assign ofs_applied       = applied_r;
    assign sync_alarm        = alarm_r;
    assign holdover          = hold_r;
    assign div_reset         = divrst_r;
    assign phase_shift_glide = mon_r[GLIDE_BIT];

endmodule : frame_align_watch

// ### rtl/frame_align_watch_pkg.sv
package frame_align_watch_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] MON_ADDR      = 8'h7C;
    localparam logic [7:0] CAL_ADDR      = 8'h7D;
    localparam logic [7:0] MON_RESET     = 8'h2B;
    localparam logic [7:0] CAL_RESET     = 8'h00;
    localparam logic [7:0] READ_ZERO     = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GLIDE_BIT  = 7;
    localparam int TOL_HI     = 6;
    localparam int TOL_LO     = 4;
    localparam int CAL_BIT    = 0;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int              OFS_W     = 16;
    localparam int              UI_W      = 4;
    localparam logic [UI_W-1:0] UI_ONE    = 4'h1;
    localparam logic [UI_W-1:0] UI_ZERO   = 4'h0;
    localparam logic [UI_W-1:0] UI_SAT    = 4'hF;
    localparam logic [OFS_W-1:0] OFS_ZERO = 16'h0000;
    localparam logic [OFS_W-1:0] OFS_ONE  = 16'h0001;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int GLIDE_STEP_NS   = 1000;
    localparam int GLIDE_DIV       = (GLIDE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GDIV_W          = 4;
    localparam logic [GDIV_W-1:0] GDIV_LAST = GDIV_W'(GLIDE_DIV - 1);
    localparam logic [GDIV_W-1:0] GDIV_ZERO = 4'h0;
    localparam logic [GDIV_W-1:0] GDIV_ONE  = 4'h1;

    // ------------------------------------------------------------
    // Calibration sequence
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CAL_IDLE,
        CAL_HOLD,
        CAL_ZERO,
        CAL_DIVRST,
        CAL_RAMP,
        CAL_DONE
    } cal_state_t;

endpackage : frame_align_watch_pkg

// ### verification/frame_align_watch_sva.sv
`timescale 1ns/1ps
// ----
// Checker
// ----
module frame_align_watch_sva
    import frame_align_watch_pkg::*;
(
    // Bus and control
    input wire logic             clk_sys, srst, cs, wr_en, rd_en, ofs_wr,
    input wire logic             sync_in, ref_clk_in, frame_mark, alarm_clr,
    input wire logic [7:0]       addr, wdata, rdata,
    input wire logic [OFS_W-1:0] ofs_value, ofs_applied,
    // Outputs
    input wire logic             sync_alarm, holdover, div_reset, phase_shift_glide
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence mon_wr; cs && wr_en && addr == MON_ADDR; endsequence
    sequence cal_go; cs && wr_en && addr == CAL_ADDR && wdata[CAL_BIT]; endsequence
    sequence cal_rd; cs && rd_en && addr == CAL_ADDR; endsequence
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> rdata == READ_ZERO
        && !holdover && !sync_alarm) else $error("reset value wrong");
    a_glide_copy: assert property (mon_wr |=> phase_shift_glide == $past(wdata[GLIDE_BIT]))
        else $error("glide bit wrong");
    a_mon_readback: assert property (mon_wr ##1 (cs && rd_en && addr == MON_ADDR && !wr_en)
        |=> rdata == $past(wdata, 2)) else $error("readback wrong");
    a_unmapped_zero: assert property (cs && rd_en && addr != MON_ADDR && addr != CAL_ADDR
        |=> rdata == READ_ZERO) else $error("unmapped read");
    a_cal_holdover: assert property (cal_go ##0 (!holdover && !$past(holdover)) |-> ##[2:3] holdover)
        else $error("holdover late");
    a_cal_clears: assert property ($fell(holdover) ##[1:3] cal_rd |=> rdata == CAL_RESET)
        else $error("cal bit stuck");
    a_div_hold: assert property (div_reset |-> holdover ##1 !div_reset)
        else $error("divider reset");
    a_alarm_latch: assert property (sync_alarm && !alarm_clr |=> sync_alarm)
        else $error("alarm dropped");
    a_offset_direct: assert property (ofs_wr && !phase_shift_glide && !holdover
        ##1 !phase_shift_glide && !holdover
        |=> ofs_applied == $past(ofs_value, 2)) else $error("offset direct");
    a_glide_step: assert property ((phase_shift_glide || holdover) && $past(phase_shift_glide
        || holdover) && !$stable(ofs_applied) |-> (ofs_applied == $past(ofs_applied) + OFS_ONE
        || ofs_applied == $past(ofs_applied) - OFS_ONE)) else $error("glide step");
endmodule : frame_align_watch_sva
bind frame_align_watch frame_align_watch_sva u_sva (.clk_sys, .srst, .cs, .wr_en, .rd_en,
    .ofs_wr, .sync_in, .ref_clk_in, .frame_mark, .alarm_clr, .addr, .wdata, .rdata,
    .ofs_value, .ofs_applied, .sync_alarm, .holdover, .div_reset, .phase_shift_glide);

// ### verification/tb.sv
`timescale 1ns/1ps
// ----
// Testbench
// ----
module tb
    import frame_align_watch_pkg::*;
;
    logic             clk_sys = 0, srst = 1, cs = 0, wr_en = 0, rd_en = 0, ofs_wr = 0;
    logic             sync_in = 0, ref_clk_in = 0, frame_mark = 0, alarm_clr = 0;
    logic             sync_alarm, holdover, div_reset, phase_shift_glide;
    logic             rd_seen = 0, div_seen = 0;
    logic [7:0]       addr = 8'h00, wdata = 8'h00, rdata;
    logic [OFS_W-1:0] ofs_value = 16'h0000, ofs_applied;
    logic [31:0]      rnd = 32'h19;
    logic [7:0]       q[$];
    int               fail_count = 0, checks = 0;
    frame_align_watch dut (.clk_sys, .srst, .cs, .wr_en, .rd_en, .addr, .wdata, .rdata,
        .ofs_wr, .ofs_value, .ofs_applied, .sync_in, .ref_clk_in, .frame_mark, .alarm_clr,
        .sync_alarm, .holdover, .div_reset, .phase_shift_glide);
    initial forever #50 clk_sys = ~clk_sys;
    always begin
        repeat (4) @(posedge clk_sys);
        ref_clk_in <= !ref_clk_in;
    end
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : xs
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk
    task automatic bus(bit w, logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        cs <= 1;
        wr_en <= w;
        rd_en <= !w;
        addr <= a;
        wdata <= d;
    endtask : bus
    task automatic rd(logic [7:0] a, logic [7:0] e);
        q.push_back(e);
        bus(0, a, 8'(xs()));
    endtask : rd
    task automatic idle();
        @(posedge clk_sys);
        cs <= 0;
        wr_en <= 0;
        rd_en <= 0;
        @(negedge clk_sys);
    endtask : idle
    task automatic ofs(logic [15:0] v);
        @(posedge clk_sys);
        ofs_wr <= 1;
        ofs_value <= v;
        @(posedge clk_sys);
        ofs_wr <= 0;
        @(negedge clk_sys);
    endtask : ofs
    task automatic mark(int gap);
        @(posedge clk_sys);
        frame_mark <= 1;
        @(posedge clk_sys);
        frame_mark <= 0;
        repeat (gap) @(posedge clk_sys);
        sync_in <= 1;
        repeat (30) @(posedge clk_sys);
        sync_in <= 0;
        @(negedge clk_sys);
    endtask : mark
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys) begin
        rd_seen <= cs && rd_en;
        if (div_reset) div_seen <= 1;
        if (rd_seen) chk("rdata", q.pop_front(), rdata);
    end
    initial begin
        #(20000 * 100);
        fail_count++;
        print_verdict();
    end
    initial begin
        logic [31:0] v;
        logic [15:0] t;
        int          n;
        repeat (5) @(posedge clk_sys);
        srst <= 0;
        rd(MON_ADDR, MON_RESET);
        rd(CAL_ADDR, CAL_RESET);
        rd(8'h33, READ_ZERO);
        idle();
        chk("glide", MON_RESET[GLIDE_BIT], phase_shift_glide);
        for (int i = 0; i < 8; i++) begin
            v = xs();
            bus(1, MON_ADDR, {1'b0, i[2:0], v[3:0]});
            rd(MON_ADDR, {1'b0, i[2:0], v[3:0]});
        end
        idle();
        $display("registers done");
        t = 16'(xs()) & 16'h003F;
        ofs(t);
        @(negedge clk_sys);
        chk("ofs direct", t, ofs_applied);
        bus(1, MON_ADDR, 8'h8B);
        idle();
        chk("glide", 1, phase_shift_glide);
        ofs(t + 16'h0003);
        chk("glide gradual", 1, ofs_applied != t + 16'h0003);
        repeat (50) @(posedge clk_sys);
        chk("glide end", t + 16'h0003, ofs_applied);
        $display("offset done");
        bus(1, CAL_ADDR, 8'h01);
        rd(CAL_ADDR, 8'h01);
        idle();
        for (n = 0; !holdover && n < 10; n++) @(posedge clk_sys);
        chk("holdover on", 1, holdover);
        for (n = 0; holdover && n < 3000; n++) @(posedge clk_sys);
        rd(CAL_ADDR, CAL_RESET);
        idle();
        chk("holdover off", 0, holdover);
        chk("div reset", 1, div_seen);
        chk("ofs restored", t + 16'h0003, ofs_applied);
        $display("calibration done");
        mark(48);
        chk("alarm", 1, sync_alarm);
        repeat (40) @(posedge clk_sys);
        chk("alarm held", 1, sync_alarm);
        @(posedge clk_sys) alarm_clr <= 1;
        @(posedge clk_sys) alarm_clr <= 0;
        @(negedge clk_sys);
        chk("alarm clear", 0, sync_alarm);
        bus(1, MON_ADDR, 8'hF0);
        idle();
        mark(12);
        chk("alarm wide", 0, sync_alarm);
        $display("sync monitor done");
        print_verdict();
    end
endmodule : tb
